/* File: core/dcfpc_pkg.sv */
// Constants, register map and state type for the dual-clock FIFO port control.
package dcfpc_pkg;
   localparam int DW = 18;
   localparam int AW = 17;
   localparam int PW = 18;
   localparam logic [PW-1:0] DEPTH = 18'h2_0000;
   localparam logic [PW-1:0] HALF = 18'h1_0000;
   localparam logic [AW-1:0] EMPTY_OFF_RST = 17'h0_007F;
   localparam logic [AW-1:0] FULL_OFF_RST = 17'h0_007F;
   // Positions of the pin inputs in the synchroniser vector.
   localparam int P_WCLK = 0;
   localparam int P_RCLK = 1;
   localparam int P_WEN = 2;
   localparam int P_REN = 3;
   localparam int P_RT = 4;
   localparam int P_OE = 5;
   localparam int P_FRST = 6;
   localparam int P_FALLTHROUGH_MODE = 7;
   localparam int P_RM = 8;
   localparam int P_STORE_PORT_ASYNC_SEL = 9;
   localparam int P_FETCH_PORT_ASYNC_SEL = 10;
   localparam int P_SSEL = 11;
   localparam int P_SLD = 12;
   localparam int P_DIN = 13;
   localparam int NPIN = 31;
   // Wishbone register byte addresses and fields.
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_LEVEL = 8'h08;
   localparam int CTRL_SOFT_RST = 0;
   localparam logic CTRL_RST_VAL = 1'h0;
   typedef enum logic [0:0] {
      RS_IDLE = 1'b0,
      RS_SETUP = 1'b1
   } dcfpc_rs_t;
endpackage

/* File: core/dcfpc_top.sv */
// Port control for a deep dual-clock FIFO with retransmit, sampled into one system clock.
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module dcfpc_top
   import dcfpc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic write_clock_i,
   input wire logic read_clock_i,
   input wire logic write_enable_n_i,
   input wire logic read_enable_n_i,
   input wire logic resend_request_n_i,
   input wire logic output_drive_n_i,
   input wire logic full_reset_n_i,
   input wire logic fallthrough_serial_pin_i,
   input wire logic resend_latency_sel_i,
   input wire logic store_port_async_sel_n_i,
   input wire logic fetch_port_async_sel_n_i,
   input wire logic serial_load_sel_i,
   input wire logic serial_load_n_i,
   input wire logic [DW-1:0] write_data_bus_i,
   output logic [DW-1:0] read_data_bus_o,
   output logic read_data_oe_o,
   output logic empty_flag_n_o,
   output logic full_flag_n_o,
   output logic near_empty_n_o,
   output logic near_full_n_o,
   output logic half_level_n_o
);
   // The array has no reset; a full reset moves only the pointers, so stale words stay out of reach except through a zero-latency resend,
   // which loads word zero and, with nothing written, leaves the read pointer past the write pointer so reads go on into stale words.
   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [NPIN-1:0] pins;
   logic [NPIN-1:0] s1;
   logic [NPIN-1:0] s2;
   logic wclk_d;
   logic rclk_d;
   logic soft_rst;
   logic freset;
   logic fallthrough_mode_mode;
   logic zero_lat;
   logic async_wr;
   logic async_rd;
   logic serial_mode;
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] rd_w1;
   logic [PW-1:0] w_r1;
   logic [PW-1:0] w_r2;
   logic full_r;
   logic [2*AW-1:0] offs;
   dcfpc_rs_t rs_state;
   dcfpc_rs_t next_rs;
   logic [PW-1:0] next_rd_ptr;
   logic [PW-1:0] next_wr_ptr;
   logic [AW-1:0] rd_addr;
   logic load;
   logic wr_edge;
   logic rd_edge;
   logic wen_low;
   logic ren_low;
   logic rt_low;
   logic rd_avail;
   logic wr_ok;
   logic [PW-1:0] cnt_w;
   logic [PW-1:0] cnt_r;
   logic [DW-1:0] first_word;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || freset);

   assign pins = {write_data_bus_i, serial_load_n_i, serial_load_sel_i, fetch_port_async_sel_n_i,
                  store_port_async_sel_n_i, resend_latency_sel_i, fallthrough_serial_pin_i,
                  full_reset_n_i, output_drive_n_i, resend_request_n_i, read_enable_n_i,
                  write_enable_n_i, read_clock_i, write_clock_i};

   // Every pin passes two flops; the second stage feeds logic, and the two clock pins also pass a third flop for edge detection.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= '0;
         s2 <= '0;
         wclk_d <= 1'b0;
         rclk_d <= 1'b0;
      end else begin
         s1 <= pins;
         s2 <= s1;
         wclk_d <= s2[P_WCLK];
         rclk_d <= s2[P_RCLK];
      end
   end

   // The pin clocks must be much slower than clk_i so each edge is seen once.
   assign freset = ~s2[P_FRST] | soft_rst;
   assign wr_edge = s2[P_WCLK] & ~wclk_d & ~freset;
   assign rd_edge = s2[P_RCLK] & ~rclk_d & ~freset;
   assign wen_low = ~s2[P_WEN] | async_wr;
   assign ren_low = ~s2[P_REN] | async_rd;
   assign rt_low = rd_edge & ~s2[P_RT];
   // Reads compare against a write pointer two read edges old, so no word is taken before
   // the empty flag has shown it; the same copy sets the fall-through latency.
   assign rd_avail = w_r2 != rd_ptr;
   assign wr_ok = wr_edge & wen_low & ~full_r;
   assign next_wr_ptr = wr_ok ? PW'(wr_ptr + 1'b1) : wr_ptr;
   assign cnt_w = PW'(next_wr_ptr - rd_w1);
   assign cnt_r = PW'(w_r1 - next_rd_ptr);
   assign first_word = mem[0];

   // Mode selects are caught while full reset is held and kept afterwards.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fallthrough_mode_mode <= 1'b0;
         zero_lat <= 1'b0;
         async_wr <= 1'b0;
         async_rd <= 1'b0;
         serial_mode <= 1'b0;
      end else if (freset) begin
         fallthrough_mode_mode <= s2[P_FALLTHROUGH_MODE] & s2[P_FETCH_PORT_ASYNC_SEL];
         zero_lat <= ~s2[P_RM];
         async_wr <= ~s2[P_STORE_PORT_ASYNC_SEL];
         async_rd <= ~s2[P_FETCH_PORT_ASYNC_SEL];
         serial_mode <= s2[P_SSEL];
      end
   end

   AST_FALLTHROUGH_MODE_SYNC: assert property (fallthrough_mode_mode |-> !async_rd)
      else $error("fall-through active with asynchronous read port");

   AST_FULL_RESET: assert property (disable iff (rst_i) freset |=>
      rd_ptr == '0 && wr_ptr == '0 && zero_lat == !$past(s2[P_RM]))
      else $error("full reset left a pointer or latency select wrong");

   // Read-side decision: resend, setup completion, or ordinary read.
   always_comb begin
      next_rd_ptr = rd_ptr;
      next_rs = rs_state;
      rd_addr = rd_ptr[AW-1:0];
      load = 1'b0;
      if (rt_low) begin
         if (zero_lat) begin
            rd_addr = '0;
            load = 1'b1;
            next_rd_ptr = PW'(1);
            next_rs = RS_IDLE;
         end else begin
            next_rd_ptr = '0;
            next_rs = RS_SETUP;
         end
      end else if (rd_edge && rs_state == RS_SETUP) begin
         next_rs = RS_IDLE;
         if (fallthrough_mode_mode && rd_avail) begin
            load = 1'b1;
            next_rd_ptr = PW'(rd_ptr + 1'b1);
         end
      end else if (rd_edge && rd_avail && (fallthrough_mode_mode ? (empty_flag_n_o | ren_low) : ren_low)) begin
         load = 1'b1;
         next_rd_ptr = PW'(rd_ptr + 1'b1);
      end
   end

   sequence s_resend;
      rt_low;
   endsequence

   sequence s_setup_done;
      rd_edge && rs_state == RS_SETUP && !rt_low && fallthrough_mode_mode && rd_avail;
   endsequence

   // Read pointer, the write pointer seen by the read side, and resend state.
   always_ff @(posedge clk_i) begin
      if (rst_i || freset) begin
         rd_ptr <= '0;
         w_r1 <= '0;
         w_r2 <= '0;
         rs_state <= RS_IDLE;
      end else if (rd_edge) begin
         rd_ptr <= next_rd_ptr;
         w_r1 <= wr_ptr;
         w_r2 <= w_r1;
         rs_state <= next_rs;
      end
   end

   AST_RESEND_PTR: assert property (s_resend ##0 !zero_lat |=> rd_ptr == '0 && rs_state == RS_SETUP)
      else $error("resend did not rewind the read pointer");

   AST_RESEND_WPTR: assert property (s_resend ##0 !wr_edge |=> $stable(wr_ptr))
      else $error("resend disturbed the write pointer");

   AST_EMPTY_IGNORE: assert property (rd_edge && !rd_avail && !rt_low && rs_state == RS_IDLE
      |=> rd_ptr == $past(rd_ptr))
      else $error("read taken from an empty memory");

   // Output register; it holds whenever nothing is loaded.
   always_ff @(posedge clk_i) begin
      if (rst_i || freset) begin
         read_data_bus_o <= '0;
         read_data_oe_o <= 1'b0;
      end else begin
         read_data_oe_o <= ~s2[P_OE];
         if (load) begin
            read_data_bus_o <= mem[rd_addr];
         end
      end
   end

   AST_ZERO_LOAD: assert property (s_resend ##0 zero_lat |=>
      read_data_bus_o == $past(first_word) && rd_ptr == PW'(1))
      else $error("zero latency resend did not load word zero");

   AST_HOLD: assert property (rd_edge && !ren_low && !fallthrough_mode_mode && !rt_low && rs_state == RS_IDLE
      |=> $stable(read_data_bus_o))
      else $error("output changed without a read request");

   // Empty flag (flagged) or output-valid (fall-through), moved on read edges only.
   always_ff @(posedge clk_i) begin
      if (rst_i || freset) begin
         empty_flag_n_o <= s2[P_FALLTHROUGH_MODE] & s2[P_FETCH_PORT_ASYNC_SEL];
         near_empty_n_o <= 1'b0;
      end else if (rd_edge) begin
         near_empty_n_o <= cnt_r > {1'b0, offs[2*AW-1:AW]};
         if (!fallthrough_mode_mode) begin
            empty_flag_n_o <= next_rs == RS_IDLE && w_r1 != next_rd_ptr;
         end else if (next_rs == RS_SETUP) begin
            empty_flag_n_o <= 1'b1;
         end else if (load) begin
            empty_flag_n_o <= 1'b0;
         end else if (ren_low) begin
            empty_flag_n_o <= 1'b1;
         end
      end
   end

   AST_STD_SETUP: assert property (s_resend ##0 !zero_lat && !fallthrough_mode_mode |=> !empty_flag_n_o)
      else $error("empty flag not low during resend setup");

   AST_FALLTHROUGH_MODE_SETUP: assert property (s_resend ##0 !zero_lat && fallthrough_mode_mode |=> empty_flag_n_o)
      else $error("output valid not cleared at resend setup");

   AST_FALLTHROUGH_MODE_DONE: assert property (s_setup_done |=>
      !empty_flag_n_o && read_data_bus_o == $past(first_word))
      else $error("setup end did not present word zero");

   AST_FALLTHROUGH_MODE_FALL: assert property (rd_edge && fallthrough_mode_mode && empty_flag_n_o && rd_avail && !rt_low
      && rs_state == RS_IDLE |=> !empty_flag_n_o)
      else $error("fall-through word not presented");

   AST_RFLAG_QUIET: assert property (!rd_edge |=> $stable(empty_flag_n_o) && $stable(near_empty_n_o))
      else $error("read-side flag moved without a read edge");

   // Memory store; retransmit never writes here.
   always_ff @(posedge clk_i) begin
      if (wr_ok) begin
         mem[wr_ptr[AW-1:0]] <= s2[P_DIN +: DW];
      end
   end

   // Write pointer, read pointer seen by the write side, full and near-full flags.
   always_ff @(posedge clk_i) begin
      if (rst_i || freset) begin
         wr_ptr <= '0;
         rd_w1 <= '0;
         full_r <= 1'b0;
         full_flag_n_o <= ~(s2[P_FALLTHROUGH_MODE] & s2[P_FETCH_PORT_ASYNC_SEL]);
         near_full_n_o <= 1'b1;
      end else if (wr_edge) begin
         wr_ptr <= next_wr_ptr;
         rd_w1 <= rd_ptr;
         full_r <= cnt_w == DEPTH;
         full_flag_n_o <= fallthrough_mode_mode ? cnt_w == DEPTH : cnt_w != DEPTH;
         near_full_n_o <= cnt_w < PW'(DEPTH - {1'b0, offs[AW-1:0]});
      end
   end

   AST_WRITE_STORE: assert property (wr_edge && wen_low && !full_r |=> wr_ptr == PW'($past(wr_ptr) + 1'b1))
      else $error("accepted write did not advance the write pointer");

   AST_NO_OVERFLOW: assert property (full_r |=> wr_ptr == $past(wr_ptr))
      else $error("write accepted while full");

   AST_FULL_PIN: assert property (!fallthrough_mode_mode |-> full_flag_n_o == !full_r)
      else $error("full flag disagrees with memory state");

   AST_WFLAG_QUIET: assert property (!wr_edge |=> $stable(full_flag_n_o) && $stable(near_full_n_o))
      else $error("write-side flag moved without a write edge");

   // Half flag: write edges can only lower it, read edges can only raise it.
   always_ff @(posedge clk_i) begin
      if (rst_i || freset) begin
         half_level_n_o <= 1'b1;
      end else if (wr_edge && cnt_w > HALF) begin
         half_level_n_o <= 1'b0;
      end else if (rd_edge && cnt_r <= HALF) begin
         half_level_n_o <= 1'b1;
      end
   end

   AST_HF_DIR: assert property (($fell(half_level_n_o) |-> $past(wr_edge)) and
      ($rose(half_level_n_o) && !$past(freset) |-> $past(rd_edge)))
      else $error("half flag moved in the wrong direction");

   // Serial offset loading shares the fall-through pin after reset.
   always_ff @(posedge clk_i) begin
      if (rst_i || freset) begin
         offs <= {EMPTY_OFF_RST, FULL_OFF_RST};
      end else if (wr_edge && serial_mode && !s2[P_SLD]) begin
         offs <= {offs[2*AW-2:0], s2[P_FALLTHROUGH_MODE]};
      end
   end

   AST_SERIAL: assert property (wr_edge && serial_mode && !s2[P_SLD] |=> offs[0] == $past(s2[P_FALLTHROUGH_MODE]))
      else $error("serial offset bit not shifted in");

   // Wishbone classic slave; ack comes one cycle after the request.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
         soft_rst <= CTRL_RST_VAL;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= '0;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
               soft_rst <= wb_dat_i[CTRL_SOFT_RST];
            end
            if (!wb_we_i) begin
               case (wb_adr_i)
                  ADR_CTRL: wb_dat_o <= {31'h0000_0000, soft_rst};
                  ADR_STATUS: wb_dat_o <= {21'h00_0000, rs_state == RS_SETUP, serial_mode, async_rd,
                                          async_wr, zero_lat, fallthrough_mode_mode, near_full_n_o,
                                          near_empty_n_o, half_level_n_o, full_flag_n_o,
                                          empty_flag_n_o};
                  ADR_LEVEL: wb_dat_o <= {14'h0000, PW'(wr_ptr - rd_ptr)};
                  default: wb_dat_o <= '0;
               endcase
            end
         end
      end
   end
endmodule // dcfpc_top

/* File: verification/dcfpc_port_model.sv */
// Behavioural writer and reader logic that drives the FIFO pin side.
`timescale 1ns/1ps
module dcfpc_port_model
   import dcfpc_pkg::*;
(
   input wire logic clk_i,
   output logic write_clock_o,
   output logic read_clock_o,
   output logic write_enable_n_o,
   output logic read_enable_n_o,
   output logic resend_request_n_o,
   output logic [DW-1:0] write_data_bus_o
);
   initial begin
      write_clock_o = 1'b0;
      read_clock_o = 1'b0;
      write_enable_n_o = 1'b1;
      read_enable_n_o = 1'b1;
      resend_request_n_o = 1'b1;
      write_data_bus_o = '0;
   end
   // One strobe is three clocks high and three low; the pin clocks stand still between strobes.
   task automatic strobe(input logic wr, input logic en_n, input logic rt_n, input logic [DW-1:0] d);
      @(posedge clk_i);
      if (wr) begin
         write_enable_n_o <= en_n;
         write_data_bus_o <= d;
         write_clock_o <= 1'b1;
      end else begin
         read_enable_n_o <= en_n;
         resend_request_n_o <= rt_n;
         read_clock_o <= 1'b1;
      end
      repeat (3) @(posedge clk_i);
      write_clock_o <= 1'b0;
      read_clock_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      // Released data is inverted so that a stale bus is never taken for a held value.
      write_data_bus_o <= ~d;
      write_enable_n_o <= 1'b1;
      read_enable_n_o <= 1'b1;
      resend_request_n_o <= 1'b1;
   endtask
endmodule // dcfpc_port_model

/* File: verification/dcfpc_tb_top.sv */
// Self-checking testbench for the dual-clock FIFO port control.
`timescale 1ns/1ps
module dcfpc_tb_top
   import dcfpc_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic frst_n = 1'b0, ft = 1'b0, rm = 1'b1, oe_n = 1'b0;
   logic store_port_async_sel_n = 1'b1, fetch_port_async_sel_n = 1'b1, ssel = 1'b0, sld_n = 1'b1;
   logic [31:0] wb_dat_o, q;
   logic wb_ack_o, wclk, rclk, wen_n, ren_n, rt_n, oe, ef_n, ff_n, ne_n, nf_n, hf_n;
   logic [DW-1:0] wd, rd;
   logic [DW-1:0] w [4];
   logic [31:0] lfsr = 32'h890a_572d;
   // Serial offsets, first bit shifted first: near-empty offset 2, near-full offset 3.
   localparam logic [33:0] OFFS_LOAD = {17'h0_0002, 17'h0_0003};
   int miscompares = 0;
   int num_checks = 0;
   always #5 clk_i = ~clk_i;
   dcfpc_port_model u_dcfpc_port_model (.clk_i(clk_i), .write_clock_o(wclk), .read_clock_o(rclk),
      .write_enable_n_o(wen_n), .read_enable_n_o(ren_n), .resend_request_n_o(rt_n), .write_data_bus_o(wd));
   dcfpc_top u_dcfpc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .write_clock_i(wclk), .read_clock_i(rclk), .write_enable_n_i(wen_n), .read_enable_n_i(ren_n),
      .resend_request_n_i(rt_n), .output_drive_n_i(oe_n), .full_reset_n_i(frst_n),
      .fallthrough_serial_pin_i(ft), .resend_latency_sel_i(rm), .store_port_async_sel_n_i(store_port_async_sel_n),
      .fetch_port_async_sel_n_i(fetch_port_async_sel_n), .serial_load_sel_i(ssel), .serial_load_n_i(sld_n),
      .write_data_bus_i(wd), .read_data_bus_o(rd), .read_data_oe_o(oe), .empty_flag_n_o(ef_n),
      .full_flag_n_o(ff_n), .near_empty_n_o(ne_n), .near_full_n_o(nf_n), .half_level_n_o(hf_n));
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Status bits 10:5 after a full reset; fall-through is refused with an asynchronous read port.
   function automatic logic [5:0] exp_modes(input logic f, input logic r);
      return {1'b0, ssel, ~fetch_port_async_sel_n, ~store_port_async_sel_n, ~r, f & fetch_port_async_sel_n};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wb(input logic w_e, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_e;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (n >= 20) begin
         miscompares++;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic put(input int i);
      lfsr = next_rand(lfsr);
      w[i] = lfsr[DW-1:0];
      u_dcfpc_port_model.strobe(1'b1, 1'b0, 1'b1, w[i]);
   endtask
   task automatic get(input logic en_n, input logic r_n);
      u_dcfpc_port_model.strobe(1'b0, en_n, r_n, '0);
   endtask
   task automatic full_rst(input logic f, input logic r);
      @(posedge clk_i);
      frst_n <= 1'b0;
      ft <= f;
      rm <= r;
      repeat (6) @(posedge clk_i);
      frst_n <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(32'(ef_n), 32'(f & fetch_port_async_sel_n));
      chk(32'(ff_n), 32'(!(f & fetch_port_async_sel_n)));
      chk(32'(rd), 32'h0000_0000);
      chk(32'({ne_n, nf_n, hf_n}), 32'h0000_0003);
      wb(1'b0, ADR_STATUS, '0);
      chk(32'(q[10:5]), 32'(exp_modes(f, r)));
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ADR_CTRL, '0);
      chk(q, 32'h0000_0000);
      wb(1'b0, 8'h40, '0);
      chk(q, 32'h0000_0000);
      full_rst(1'b0, 1'b1);
      chk(32'(oe), 32'h0000_0001);
      for (int i = 0; i < 4; i++) put(i);
      get(1'b1, 1'b1);
      get(1'b1, 1'b1);
      chk(32'(ef_n), 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         get(1'b0, 1'b1);
         chk(32'(rd), 32'(w[i]));
      end
      get(1'b1, 1'b1);
      chk(32'(rd), 32'(w[2]));
      get(1'b1, 1'b0);
      chk(32'(ef_n), 32'h0000_0000);
      get(1'b1, 1'b1);
      chk(32'(ef_n), 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         get(1'b0, 1'b1);
         chk(32'(rd), 32'(w[i]));
      end
      chk(32'(ef_n), 32'h0000_0000);
      get(1'b0, 1'b1);
      chk(32'(rd), 32'(w[3]));
      full_rst(1'b1, 1'b1);
      put(0);
      get(1'b1, 1'b1);
      get(1'b1, 1'b1);
      chk(32'(ef_n), 32'h0000_0001);
      get(1'b1, 1'b1);
      chk(32'(rd), 32'(w[0]));
      chk(32'(ef_n), 32'h0000_0000);
      put(1);
      repeat (3) get(1'b1, 1'b1);
      get(1'b0, 1'b1);
      chk(32'(rd), 32'(w[1]));
      get(1'b0, 1'b1);
      chk(32'(ef_n), 32'h0000_0001);
      get(1'b1, 1'b0);
      chk(32'(ef_n), 32'h0000_0001);
      get(1'b1, 1'b1);
      chk(32'(ef_n), 32'h0000_0000);
      chk(32'(rd), 32'(w[0]));
      full_rst(1'b0, 1'b0);
      for (int i = 0; i < 3; i++) put(i);
      get(1'b1, 1'b1);
      get(1'b1, 1'b1);
      get(1'b0, 1'b1);
      get(1'b0, 1'b1);
      chk(32'(rd), 32'(w[1]));
      get(1'b0, 1'b0);
      chk(32'(rd), 32'(w[0]));
      get(1'b0, 1'b1);
      chk(32'(rd), 32'(w[1]));
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      wb(1'b0, ADR_CTRL, '0);
      chk(q, 32'h0000_0001);
      wb(1'b1, ADR_CTRL, 32'h0000_0000);
      repeat (6) @(posedge clk_i);
      chk(32'(ef_n), 32'h0000_0000);
      chk(32'(rd), 32'h0000_0000);
      ssel <= 1'b1;
      full_rst(1'b0, 1'b1);
      sld_n <= 1'b0;
      for (int i = 33; i >= 0; i--) begin
         ft <= OFFS_LOAD[i];
         u_dcfpc_port_model.strobe(1'b1, 1'b1, 1'b1, '0);
      end
      sld_n <= 1'b1;
      ssel <= 1'b0;
      for (int i = 0; i < 3; i++) put(i);
      get(1'b1, 1'b1);
      get(1'b1, 1'b1);
      chk(32'(ne_n), 32'h0000_0001);
      get(1'b0, 1'b1);
      chk(32'(ne_n), 32'h0000_0000);
      chk(32'(rd), 32'(w[0]));
      wb(1'b0, ADR_LEVEL, '0);
      chk(q, 32'h0000_0002);
      store_port_async_sel_n <= 1'b0;
      fetch_port_async_sel_n <= 1'b0;
      full_rst(1'b1, 1'b1);
      put(0);
      put(1);
      get(1'b0, 1'b1);
      get(1'b0, 1'b1);
      chk(32'(ef_n), 32'h0000_0001);
      get(1'b0, 1'b1);
      chk(32'(rd), 32'(w[0]));
      get(1'b0, 1'b1);
      chk(32'(rd), 32'(w[1]));
      chk(32'(ef_n), 32'h0000_0000);
      oe_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(32'(oe), 32'h0000_0000);
      end_sim();
   end
   // The whole sequence needs well under a thousand cycles; the limit leaves ample margin.
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      end_sim();
   end
endmodule // dcfpc_tb_top
